// ---- core/tfl_consts.svh ----
`ifndef TFL_CONSTS_SVH
`define TFL_CONSTS_SVH

// ==========================================================
// Clock
`define TFL_CLK_NS 5
`define TFL_CEIL_CYC(ns) (((ns) + `TFL_CLK_NS - 1) / `TFL_CLK_NS)
`define TFL_FLOOR_CYC(ns) ((ns) / `TFL_CLK_NS)

// ==========================================================
// Frame layout
`define TFL_FRAME_BITS 40
`define TFL_HDR_HI 8'hFA
`define TFL_HDR_LO_NIB 4'hA
`define TFL_HDR_MSB 39
`define TFL_ADDR_MSB 23
`define TFL_DATA_MSB 15
`define TFL_DEV_ADDR_DEF 4'h0

// ==========================================================
// Register offsets and reset values
`define TFL_OFS_HIGH_WORD 8'h06
`define TFL_OFS_LOW_BITS 8'h07
`define TFL_LOW_BITS_W 7
`define TFL_CTRL_W 23
`define TFL_HIGH_RST 16'h0000
`define TFL_LOW_RST 7'h00

// ==========================================================
// Link timing
`define TFL_FRAME_MIN_NS 40000
`define TFL_FRAME_MIN_CYC `TFL_CEIL_CYC(`TFL_FRAME_MIN_NS)
`define TFL_GAP_MIN_NS 2000
`define TFL_GAP_MIN_CYC `TFL_CEIL_CYC(`TFL_GAP_MIN_NS)
`define TFL_DRIVE_NS 200
`define TFL_DRIVE_CYC `TFL_CEIL_CYC(`TFL_DRIVE_NS)
`define TFL_MID_NS 250
`define TFL_MID_CYC `TFL_CEIL_CYC(`TFL_MID_NS)
`define TFL_IDLE_TMO_NS 10000
`define TFL_IDLE_TMO_CYC `TFL_FLOOR_CYC(`TFL_IDLE_TMO_NS)
`define TFL_FDELAY_MAX_NS 8000
`define TFL_FDELAY_MAX_CYC `TFL_FLOOR_CYC(`TFL_FDELAY_MAX_NS)
`define TFL_SETTLE_MAX_NS 30000

// ==========================================================
// Host value arithmetic
`define TFL_K_FRAC 12
`define TFL_ROUND_HALF 41'h00000000800

`endif

// ---- core/tfl_pkg.sv ----
`default_nettype none
package tfl_pkg;
	// ==========================================================
	// Device state
	typedef enum logic [1:0] {
		SYM_MID,
		SYM_HI,
		SYM_LO
	} tfl_sym_type;

	typedef struct packed {
		logic [1:0] sync_hi;
		logic [1:0] sync_lo;
		tfl_sym_type sym;
		logic [39:0] shreg;
		logic [5:0] bit_cnt;
		logic [11:0] idle_cnt;
		logic [15:0] high_word;
		logic [6:0] low_bits;
		logic [22:0] ctrl;
		logic update;
		logic frame_ok;
		logic frame_drop;
	} tfl_dev_state_type;

	// ==========================================================
	// Host state
	typedef enum logic [2:0] {
		H_IDLE,
		H_SETUP,
		H_DRIVE,
		H_MID,
		H_PAD,
		H_GAP
	} tfl_host_fsm_type;

	typedef struct packed {
		tfl_host_fsm_type fsm;
		logic [13:0] ph_cnt;
		logic [13:0] frame_cnt;
		logic [5:0] bit_idx;
		logic [39:0] sh;
		logic second;
		logic [15:0] high_word;
		logic pin_data;
		logic pin_oe;
		logic done;
	} tfl_host_state_type;
endpackage : tfl_pkg
`default_nettype wire

// ---- core/tfl_link_if.sv ----
`default_nettype none
interface tfl_link_if;
	// Host pin drivers
	logic pin_data;
	logic pin_oe;
	// Levels seen at the device pin; released line rests mid
	logic level_hi;
	logic level_lo;
	assign level_hi = pin_oe & pin_data;
	assign level_lo = pin_oe & ~pin_data;
	modport host (output pin_data, output pin_oe);
	modport dev (input level_hi, input level_lo);
endinterface : tfl_link_if
`default_nettype wire

// ---- core/tfl_host.sv ----
`include "tfl_consts.svh"
`default_nettype none
module tfl_host
	import tfl_pkg::*;
#(
	parameter int FRAME_MIN_CYC = `TFL_FRAME_MIN_CYC
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Configuration
	input wire logic mode2_i,
	input wire logic [3:0] dev_addr_i,
	input wire logic [23:0] scale_k_i,
	// Request
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic signed [15:0] ppm_i,
	output logic done_o,
	// Link
	tfl_link_if.host link
);
	tfl_host_state_type s_reg;
	tfl_host_state_type s_next;
	logic signed [40:0] prod;
	logic signed [40:0] rounded;
	logic [22:0] value;
	logic [15:0] hi_w;
	logic [15:0] lo_w;
	logic [15:0] hdr;

	// ==========================================================
	// Control value
	// K comes from software, fixed point with 12 fraction bits
	assign prod = ppm_i * $signed({1'b0, scale_k_i});
	assign rounded = (prod + $signed(`TFL_ROUND_HALF)) >>> `TFL_K_FRAC;
	assign value = rounded[22:0];
	assign hi_w = mode2_i ? value[22:7] : value[15:0];
	assign lo_w = {9'h000, value[6:0]};
	assign hdr = {`TFL_HDR_HI, dev_addr_i, `TFL_HDR_LO_NIB};

	// ==========================================================
	// Frame sequencer
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (s_reg.fsm != H_IDLE && s_reg.fsm != H_GAP) begin
			s_next.frame_cnt = s_reg.frame_cnt + 14'h0001;
		end
		case (s_reg.fsm)
			H_IDLE: begin
				if (req_valid_i) begin
					s_next.frame_cnt = 14'h0000;
					s_next.bit_idx = 6'h00;
					s_next.ph_cnt = 14'h0000;
					s_next.high_word = hi_w;
					// Low word goes first in mode 2
					if (mode2_i) begin
						s_next.sh = {hdr, `TFL_OFS_LOW_BITS, lo_w};
						s_next.second = 1'b1;
					end else begin
						s_next.sh = {hdr, `TFL_OFS_HIGH_WORD, hi_w};
						s_next.second = 1'b0;
					end
					s_next.fsm = H_SETUP;
				end
			end
			H_SETUP: begin
				// Data settles a cycle before enable to avoid glitches
				s_next.pin_data = s_reg.sh[`TFL_HDR_MSB];
				s_next.fsm = H_DRIVE;
			end
			H_DRIVE: begin
				s_next.pin_oe = 1'b1;
				s_next.ph_cnt = s_reg.ph_cnt + 14'h0001;
				if (s_reg.ph_cnt == 14'(`TFL_DRIVE_CYC)) begin
					s_next.pin_oe = 1'b0;
					s_next.ph_cnt = 14'h0000;
					s_next.fsm = H_MID;
				end
			end
			H_MID: begin
				s_next.ph_cnt = s_reg.ph_cnt + 14'h0001;
				// Long release lets the divider settle within 5%
				if (s_reg.ph_cnt == 14'(`TFL_MID_CYC - 1)) begin
					s_next.ph_cnt = 14'h0000;
					s_next.sh = {s_reg.sh[38:0], 1'b0};
					s_next.bit_idx = s_reg.bit_idx + 6'h01;
					if (s_reg.bit_idx == 6'(`TFL_FRAME_BITS - 1)) begin
						s_next.fsm = H_PAD;
					end else begin
						s_next.fsm = H_SETUP;
					end
				end
			end
			H_PAD: begin
				if (s_reg.frame_cnt >= 14'(FRAME_MIN_CYC)) begin
					s_next.ph_cnt = 14'h0000;
					s_next.fsm = H_GAP;
				end
			end
			H_GAP: begin
				s_next.ph_cnt = s_reg.ph_cnt + 14'h0001;
				if (s_reg.ph_cnt == 14'(`TFL_GAP_MIN_CYC - 1)) begin
					s_next.ph_cnt = 14'h0000;
					if (s_reg.second) begin
						s_next.second = 1'b0;
						s_next.frame_cnt = 14'h0000;
						s_next.bit_idx = 6'h00;
						s_next.sh = {hdr, `TFL_OFS_HIGH_WORD, s_reg.high_word};
						s_next.fsm = H_SETUP;
					end else begin
						s_next.done = 1'b1;
						s_next.fsm = H_IDLE;
					end
				end
			end
			default: begin
				s_next.pin_oe = 1'b0;
				s_next.fsm = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign req_ready_o = (s_reg.fsm == H_IDLE);
	assign done_o = s_reg.done;
	assign link.pin_data = s_reg.pin_data;
	assign link.pin_oe = s_reg.pin_oe;
endmodule : tfl_host
`default_nettype wire

// ---- core/tfl_dev.sv ----
`include "tfl_consts.svh"
`default_nettype none
// Operation
// - Frame at least 40 us, gap 2 us
// - Output follows commit well within 8 us
// - Control value signed, 16 or 23 bits
// - Upper 16 bits go to offset 06
// - Low 7 bits go to offset 07
// - Host scale factor from pull range
// - Host rounds ppm times factor, two's complement
// - Offset 07 holds; offset 06 commits both
// - One wire, three levels, ends mid
// - High then mid is one, low zero
// - Bit period covers drive plus mid
// - Hold mid long enough to settle
// - Change data before enabling the driver
// - 40 bits MSB first: header, address, data
// - Header FA, address nibble, A
// - Mode 2 low frame first; mode 1 single
// - Both control registers reset to zero
module tfl_dev
	import tfl_pkg::*;
#(
	parameter logic [3:0] DEV_ADDR = `TFL_DEV_ADDR_DEF
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Configuration
	input wire logic mode2_i,
	// Link
	tfl_link_if.dev link,
	// Frequency control
	output logic [22:0] freq_ctrl_o,
	output logic freq_update_o,
	output logic [15:0] high_word_o,
	output logic [6:0] low_bits_o,
	// Frame status
	output logic frame_ok_o,
	output logic frame_drop_o
);
	tfl_dev_state_type s_reg;
	tfl_dev_state_type s_next;
	tfl_sym_type sym_now;
	logic bit_done;
	logic bit_val;
	logic [39:0] sh_new;
	logic [15:0] hdr_exp;
	logic [15:0] f_hdr;
	logic [7:0] f_addr;
	logic [15:0] f_data;
	logic frame_end;
	logic hdr_match;

	// ==========================================================
	// Symbol decode
	// Both pins settle through two flops before any decode
	always_comb begin
		sym_now = SYM_MID;
		if (s_reg.sync_hi[1] && !s_reg.sync_lo[1]) begin
			sym_now = SYM_HI;
		end else if (s_reg.sync_lo[1] && !s_reg.sync_hi[1]) begin
			sym_now = SYM_LO;
		end
	end

	// A bit completes when the line returns to mid
	assign bit_done = (s_reg.sym != SYM_MID) && (sym_now == SYM_MID);
	assign bit_val = (s_reg.sym == SYM_HI);
	assign sh_new = {s_reg.shreg[38:0], bit_val};
	assign frame_end = bit_done && (s_reg.bit_cnt == 6'(`TFL_FRAME_BITS - 1));

	// ==========================================================
	// Frame fields
	assign hdr_exp = {`TFL_HDR_HI, DEV_ADDR, `TFL_HDR_LO_NIB};
	assign f_hdr = sh_new[`TFL_HDR_MSB -: 16];
	assign f_addr = sh_new[`TFL_ADDR_MSB -: 8];
	assign f_data = sh_new[`TFL_DATA_MSB -: 16];
	assign hdr_match = (f_hdr == hdr_exp);

	// ==========================================================
	// Next state
	always_comb begin
		s_next = s_reg;
		s_next.sync_hi = {s_reg.sync_hi[0], link.level_hi};
		s_next.sync_lo = {s_reg.sync_lo[0], link.level_lo};
		s_next.sym = sym_now;
		s_next.update = 1'b0;
		s_next.frame_ok = 1'b0;
		s_next.frame_drop = 1'b0;

		// Idle watchdog runs only inside a frame
		if (sym_now != SYM_MID || s_reg.bit_cnt == 6'h00) begin
			s_next.idle_cnt = 12'h000;
		end else begin
			s_next.idle_cnt = s_reg.idle_cnt + 12'h001;
		end

		if (bit_done) begin
			s_next.shreg = sh_new;
			s_next.bit_cnt = s_reg.bit_cnt + 6'h01;
			s_next.idle_cnt = 12'h000;
		end else if (s_reg.bit_cnt != 6'h00
			&& s_reg.idle_cnt == 12'(`TFL_IDLE_TMO_CYC - 1)) begin
			// Stalled frame: throw away, next header starts clean
			s_next.bit_cnt = 6'h00;
			s_next.idle_cnt = 12'h000;
			s_next.frame_drop = 1'b1;
		end

		if (frame_end) begin
			s_next.bit_cnt = 6'h00;
			if (!hdr_match) begin
				// Registers untouched on a foreign header
				s_next.frame_drop = 1'b1;
			end else begin
				case (f_addr)
					`TFL_OFS_LOW_BITS: begin
						// Stored only; freq_ctrl_o stays put
						s_next.low_bits = f_data[6:0];
						s_next.frame_ok = 1'b1;
					end
					`TFL_OFS_HIGH_WORD: begin
						s_next.high_word = f_data;
						s_next.frame_ok = 1'b1;
						s_next.update = 1'b1;
						if (mode2_i) begin
							s_next.ctrl = {f_data, s_reg.low_bits};
						end else begin
							// Mode 1 value sign-extended to 23 bits
							s_next.ctrl = {{7{f_data[15]}}, f_data};
						end
					end
					default: begin
						s_next.frame_drop = 1'b1;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_reg <= '0;
			s_reg.high_word <= `TFL_HIGH_RST;
			s_reg.low_bits <= `TFL_LOW_RST;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Outputs
	assign freq_ctrl_o = s_reg.ctrl;
	assign freq_update_o = s_reg.update;
	assign high_word_o = s_reg.high_word;
	assign low_bits_o = s_reg.low_bits;
	assign frame_ok_o = s_reg.frame_ok;
	assign frame_drop_o = s_reg.frame_drop;
endmodule : tfl_dev
`default_nettype wire

// ---- dv/tfl_link_sva.sv ----
`default_nettype none
module tfl_link_sva #(
	parameter int FRAME_MIN_CYC = 8000
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Link
	input wire logic pin_data,
	input wire logic pin_oe,
	input wire logic level_hi,
	input wire logic level_lo
);
	// ====
	// Mid and start counters saturate so reset reads as a long idle
	logic prev_reg;
	logic rise;
	logic [5:0] drv_reg;
	logic [5:0] bit_reg;
	logic [15:0] mid_reg;
	logic [15:0] start_reg;
	assign rise = pin_oe & ~prev_reg;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			prev_reg <= 1'b0;
			drv_reg <= 6'h00;
			bit_reg <= 6'h00;
			mid_reg <= 16'hFFFF;
			start_reg <= 16'hFFFF;
		end else begin
			prev_reg <= pin_oe;
			drv_reg <= pin_oe ? drv_reg + 6'h01 : 6'h00;
			mid_reg <= pin_oe ? 16'h0000 : mid_reg + {15'h0000, mid_reg != 16'hFFFF};
			if (prev_reg && !pin_oe) begin
				bit_reg <= (bit_reg == 6'h27) ? 6'h00 : bit_reg + 6'h01;
			end
			if (rise && bit_reg == 6'h00) begin
				start_reg <= 16'h0001;
			end else begin
				start_reg <= start_reg + {15'h0000, start_reg != 16'hFFFF};
			end
		end
	end
	// ====
	// Properties
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	property p_clean_en;
		$rose(pin_oe) |-> $stable(pin_data);
	endproperty
	a_clean_en: assert property (p_clean_en) else $error("data moved at enable");
	property p_hold;
		pin_oe && $past(pin_oe) |-> $stable(pin_data);
	endproperty
	a_hold: assert property (p_hold) else $error("data moved while driven");
	property p_drive_len;
		$fell(pin_oe) |-> drv_reg == 6'h28;
	endproperty
	a_drive_len: assert property (p_drive_len) else $error("drive phase length");
	property p_mid_len;
		rise |-> mid_reg >= 16'h0032;
	endproperty
	a_mid_len: assert property (p_mid_len) else $error("mid phase too short");
	property p_gap;
		rise && bit_reg == 6'h00 |-> mid_reg >= 16'h0190;
	endproperty
	a_gap: assert property (p_gap) else $error("frame gap too short");
	property p_frame_len;
		rise && bit_reg == 6'h00 |-> start_reg >= FRAME_MIN_CYC + 390;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame too short");
	property p_bits;
		rise && mid_reg >= 16'h012C |-> bit_reg == 6'h00;
	endproperty
	a_bits: assert property (p_bits) else $error("frame bit count");
	property p_levels;
		(level_hi | level_lo) == pin_oe && !(level_hi && level_lo);
	endproperty
	a_levels: assert property (p_levels) else $error("line level");
endmodule : tfl_link_sva
`default_nettype wire

// ---- dv/tri_level_freq_control_link_bench.sv ----
`default_nettype none
module tri_level_freq_control_link_bench;
	timeunit 1ns;
	timeprecision 100ps;
	// Full 40 us minimum, so the host really pads
	localparam int FMIN = 8000;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic mode2 = 1'b0;
	logic [3:0] dev_addr = 4'h3;
	logic [23:0] scale_k = 24'h001000;
	logic req_valid = 1'b0;
	logic signed [15:0] ppm = 16'sh0000;
	logic req_ready, done, upd, ok, drop, ok2, drop2;
	logic [22:0] ctrl, ctrl2;
	logic [15:0] hw, last_hw;
	logic [6:0] lb, last_lb;
	logic [22:0] notes[$];
	int n_fail = 0;
	int tests_run = 0;
	int n_drop = 0;
	int n_ok2 = 0;
	int n_drop2 = 0;
	tfl_link_if lnk();
	tfl_link_if lnk2();
	always #2.5 clk_sys_i = ~clk_sys_i;
	tfl_host #(.FRAME_MIN_CYC(FMIN)) u_tfl_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.ce_i(1'b1), .mode2_i(mode2), .dev_addr_i(dev_addr), .scale_k_i(scale_k),
		.req_valid_i(req_valid), .req_ready_o(req_ready), .ppm_i(ppm), .done_o(done),
		.link(lnk.host));
	tfl_dev #(.DEV_ADDR(4'h3)) u_tfl_dev (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
		.mode2_i(mode2), .link(lnk.dev), .freq_ctrl_o(ctrl), .freq_update_o(upd),
		.high_word_o(hw), .low_bits_o(lb), .frame_ok_o(ok), .frame_drop_o(drop));
	tfl_dev u_tfl_dev_2 (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1), .mode2_i(mode2),
		.link(lnk2.dev), .freq_ctrl_o(ctrl2), .freq_update_o(), .high_word_o(),
		.low_bits_o(), .frame_ok_o(ok2), .frame_drop_o(drop2));
	tfl_link_sva #(.FRAME_MIN_CYC(FMIN)) u_tfl_link_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.pin_data(lnk.pin_data), .pin_oe(lnk.pin_oe), .level_hi(lnk.level_hi),
		.level_lo(lnk.level_lo));
	// ====
	// Tasks
	task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : cyc
	task automatic send(input logic m2, input logic [3:0] adr, input logic signed [15:0] p,
		input logic [23:0] k);
		logic signed [40:0] prod;
		logic [22:0] v;
		int i;
		prod = p * $signed({1'b0, k});
		prod = prod + 41'sh00000000800;
		v = 23'(prod >>> 12);
		mode2 = m2;
		dev_addr = adr;
		ppm = p;
		scale_k = k;
		req_valid = 1'b1;
		if (adr == 4'h3) begin
			notes.push_back(m2 ? v : {{7{v[15]}}, v[15:0]});
			last_hw = m2 ? v[22:7] : v[15:0];
			last_lb = m2 ? v[6:0] : last_lb;
		end
		cyc(1);
		req_valid = 1'b0;
		i = 0;
		while (done !== 1'b1 && i < 20000) begin
			cyc(1);
			i++;
		end
		if (i == 20000) begin
			n_fail++;
			conclude();
		end
		chk("high_word", {7'h00, last_hw}, {7'h00, hw});
		chk("low_bits", {16'h0000, last_lb}, {16'h0000, lb});
	endtask : send
	task automatic tx(input logic [39:0] f, input int nb);
		for (int b = 39; b > 39 - nb; b--) begin
			lnk2.pin_data = f[b];
			cyc(1);
			lnk2.pin_oe = 1'b1;
			cyc(41);
			lnk2.pin_oe = 1'b0;
			// Data moves a cycle after release, never with the enable
			cyc(1);
			lnk2.pin_data = ~f[b];
			cyc(49);
		end
		// Pad to the 40 us frame, then the 2 us gap
		cyc(4720);
	endtask : tx
	// ====
	// Result watcher
	always @(posedge clk_sys_i) begin
		#1;
		n_drop += int'(drop === 1'b1);
		n_ok2 += int'(ok2 === 1'b1);
		n_drop2 += int'(drop2 === 1'b1);
		if (upd === 1'b1) begin
			chk("notes pending", 23'h000001, {22'h0, notes.size() > 0});
			if (notes.size() > 0) begin
				chk("freq_ctrl", notes.pop_front(), ctrl);
			end
		end
	end
	// ====
	// Main sequence
	initial begin
		void'($urandom(11));
		lnk2.pin_data = 1'b0;
		lnk2.pin_oe = 1'b0;
		last_hw = 16'h0000;
		last_lb = 7'h00;
		cyc(2);
		rst_i = 1'b0;
		chk("ctrl at reset", 23'h000000, ctrl);
		for (int n = 0; n < 5; n++) begin
			send(n[0], 4'h3, (n < 4) ? (n[1] ? 16'sh8000 : 16'sh7FFF) : 16'($urandom),
				(n < 4) ? 24'hFFFFFF : 24'($urandom));
		end
		send(1'b0, 4'h5, 16'sh0100, 24'h001000);
		chk("bad header drops", 23'h000001, 23'(n_drop));
		mode2 = 1'b1;
		ppm = 16'sh0200;
		req_valid = 1'b1;
		cyc(1);
		req_valid = 1'b0;
		cyc(300);
		rst_i = 1'b1;
		cyc(2);
		rst_i = 1'b0;
		chk("ctrl after reset", 23'h000000, ctrl);
		chk("high after reset", 23'h000000, {7'h00, hw});
		chk("low after reset", 23'h000000, {16'h0000, lb});
		mode2 = 1'b0;
		tx({8'hFA, 4'h0, 4'hA, 8'h06, 16'h1234}, 30);
		cyc(2100);
		chk("partial dropped", 23'h000001, 23'(n_drop2));
		tx({8'hFA, 4'h0, 4'hA, 8'h05, 16'h1234}, 40);
		chk("bad register dropped", 23'h000002, 23'(n_drop2));
		tx({8'hFA, 4'h0, 4'hA, 8'h06, 16'h8001}, 40);
		chk("frame accepted", 23'h000001, 23'(n_ok2));
		chk("decoded value", 23'h7F8001, ctrl2);
		conclude();
	end
endmodule : tri_level_freq_control_link_bench
`default_nettype wire
